/* design/agc_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "agc_regs.svh"
module agc_top
    import agc_pkg::*;
(
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic                       pready,
    output logic [31:0]                prdata,
    output logic                       pslverr,
    input  wire logic                  ext_trigger,
    input  wire agc_pkg::agc_core_resp_t core_resp,
    output agc_pkg::agc_core_ctrl_t    core_ctrl,
    output logic                       irq
);
    import agc_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // register state
    logic [12:0] ctrl_q, ctrl_d;
    logic [7:0]  pre_q, pre_d, acq_q, acq_d, rpt_q, rpt_d;
    logic [4:0]  cap_q, cap_d;
    logic [15:0] thr_q, thr_d;
    logic [2:0]  ien_q, ien_d;
    logic        pready_q, pready_d, pslverr_q, pslverr_d;
    logic [31:0] prdata_q, prdata_d;
    logic        irq_q, irq_d;
    logic        wr_acc, go_wr, aclr_wr, clr_wr;
    agc_mode_t   mode;
    logic        dse;
    logic [2:0]  shift;

    // mode written together with go applies to that conversion
    assign mode  = agc_mode_t'(ctrl_d[`AGC_CTRL_MODE_LSB +: 3]);
    assign dse   = ctrl_q[`AGC_CTRL_DSE];
    assign shift = ctrl_q[`AGC_CTRL_SHIFT_LSB +: 3];

    ////////////////////////////////////////////////////////////////////
    // compute state
    logic [9:0]  cur_q, cur_d, prev_q, prev_d;
    logic [15:0] acc_q, acc_d;
    logic [7:0]  cnt_q, cnt_d;
    logic [2:0]  st_q, st_d;
    logic        avg_clr_q, avg_clr_d, burst_q, burst_d;
    logic        restart_q, restart_d;
    logic        s1_q, s2_q, s3_q, trig_lvl_q, trig_lvl_d;
    logic        ext_rise, trig, seq_start;
    logic        busy, conv_end, cycle_end;

    function automatic logic [31:0] rd_mux(input logic [7:0] a,
                                           input logic [31:0] busy_w);
        case (a)
            `AGC_OFS_CTRL:     rd_mux = {19'h0, ctrl_q} | busy_w;
            `AGC_OFS_PRE_TIME: rd_mux = {24'h0, pre_q};
            `AGC_OFS_ACQ_TIME: rd_mux = {24'h0, acq_q};
            `AGC_OFS_CAP:      rd_mux = {27'h0, cap_q};
            `AGC_OFS_REPEAT:   rd_mux = {24'h0, rpt_q};
            `AGC_OFS_THRESH:   rd_mux = {16'h0, thr_q};
            `AGC_OFS_RESULT:   rd_mux = {22'h0, cur_q};
            `AGC_OFS_PREV:     rd_mux = {22'h0, prev_q};
            `AGC_OFS_ACC:      rd_mux = {16'h0, acc_q};
            `AGC_OFS_COUNT:    rd_mux = {24'h0, cnt_q};
            `AGC_OFS_STATUS:   rd_mux = {29'h0, st_q};
            `AGC_OFS_INT_EN:   rd_mux = {29'h0, ien_q};
            default:           rd_mux = 32'h0;
        endcase
    endfunction : rd_mux

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a[1:0] == 2'h0) && (a <= `AGC_OFS_INT_CLR);
    endfunction : mapped

    ////////////////////////////////////////////////////////////////////
    // apb slave: one wait state, write lands on the pready edge
    assign wr_acc  = psel && penable && pready_q && pwrite
                     && mapped(paddr);
    assign go_wr   = wr_acc && (paddr == `AGC_OFS_CTRL)
                     && pwdata[`AGC_CTRL_GO];
    assign aclr_wr = wr_acc && (paddr == `AGC_OFS_CTRL)
                     && pwdata[`AGC_CTRL_ACLR];
    assign clr_wr  = wr_acc && (paddr == `AGC_OFS_INT_CLR);

    always_comb begin
        ctrl_d    = ctrl_q;
        pre_d     = pre_q;
        acq_d     = acq_q;
        cap_d     = cap_q;
        rpt_d     = rpt_q;
        thr_d     = thr_q;
        ien_d     = ien_q;
        pready_d  = psel && penable && !pready_q;
        pslverr_d = pready_d && !mapped(paddr);
        prdata_d  = prdata_q;
        if (pready_d && !pwrite) begin
            prdata_d = rd_mux(paddr, {23'h0, busy | burst_q, 8'h0});
        end
        if (wr_acc) begin
            case (paddr)
                `AGC_OFS_CTRL: begin
                    // go and clear are strobes and never stored
                    ctrl_d = pwdata[12:0] & 13'h1cff;
                end
                `AGC_OFS_PRE_TIME: pre_d = pwdata[7:0];
                `AGC_OFS_ACQ_TIME: acq_d = pwdata[7:0];
                `AGC_OFS_CAP:      cap_d = pwdata[4:0];
                `AGC_OFS_REPEAT:   rpt_d = pwdata[7:0];
                `AGC_OFS_THRESH:   thr_d = pwdata[15:0];
                `AGC_OFS_INT_EN:   ien_d = pwdata[2:0];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q    <= `AGC_RST_CTRL;
            pre_q     <= `AGC_RST_BYTE;
            acq_q     <= `AGC_RST_BYTE;
            cap_q     <= `AGC_RST_CAP;
            rpt_q     <= `AGC_RST_BYTE;
            thr_q     <= `AGC_RST_THRESH;
            ien_q     <= 3'h0;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0;
        end else begin
            ctrl_q    <= ctrl_d;
            pre_q     <= pre_d;
            acq_q     <= acq_d;
            cap_q     <= cap_d;
            rpt_q     <= rpt_d;
            thr_q     <= thr_d;
            ien_q     <= ien_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q  <= prdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // trigger pin synchroniser, change counts when stages 2 and 3 agree
    assign ext_rise = (s2_q == s3_q) && s3_q && !trig_lvl_q;
    always_comb begin
        trig_lvl_d = (s2_q == s3_q) ? s3_q : trig_lvl_q;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q       <= 1'b0;
            s2_q       <= 1'b0;
            s3_q       <= 1'b0;
            trig_lvl_q <= 1'b0;
        end else begin
            s1_q       <= ext_trigger;
            s2_q       <= s1_q;
            s3_q       <= s2_q;
            trig_lvl_q <= trig_lvl_d;
        end
    end

    assign trig      = (go_wr || ext_rise) && !busy && !burst_q;
    assign seq_start = trig || restart_q;

    agc_seq u_seq (
        .pclk                       (pclk),
        .presetn                    (presetn),
        .start                      (seq_start),
        .precharge_time             (pre_q),
        .acq_time                   (acq_q),
        .double_sample_en           (dse),
        .guard_polarity             (ctrl_d[`AGC_CTRL_GPOL]),
        .second_precharge_invert_en (ctrl_d[`AGC_CTRL_IPEN]),
        .cap_sel                    (cap_q),
        .core_done                  (core_resp.done),
        .core_ctrl                  (core_ctrl),
        .busy                       (busy),
        .conv_end                   (conv_end),
        .cycle_end                  (cycle_end)
    );

    ////////////////////////////////////////////////////////////////////
    // computation
    logic signed [17:0] samp, sum;
    logic [15:0]        base, filt;
    logic [7:0]         cnt_inc;
    logic               test, ovf;

    always_comb begin
        cur_d     = cur_q;
        prev_d    = prev_q;
        acc_d     = acc_q;
        cnt_d     = cnt_q;
        avg_clr_d = avg_clr_q;
        burst_d   = burst_q;
        restart_d = 1'b0;
        st_d      = st_q;
        test      = 1'b0;
        ovf       = 1'b0;
        filt      = 16'h0;
        base      = acc_q;
        // previous result is sample one, current sample two
        samp = dse ? ($signed({8'h0, core_resp.result})
                      - $signed({8'h0, cur_q}))
                   : $signed({8'h0, core_resp.result});
        if (trig && ((mode == AGC_MODE_AVG && avg_clr_q)
                     || mode == AGC_MODE_BURST)) begin
            base      = 16'h0;
            cnt_d     = 8'h0;
            avg_clr_d = 1'b0;
            burst_d   = (mode == AGC_MODE_BURST);
        end
        if (mode == AGC_MODE_LPF) begin
            sum = samp + $signed({2'h0, base})
                  - $signed({2'h0, base >> shift});
        end else begin
            sum = samp + $signed({2'h0, base});
        end
        cnt_inc = (cnt_d == `AGC_CNT_MAX) ? cnt_d
                                          : cnt_d + 8'h01;
        if (trig) begin
            acc_d = base;
        end
        if (conv_end) begin
            prev_d = cur_q;
            cur_d  = core_resp.result;
            st_d[`AGC_ST_DONE] = 1'b1;
        end
        if (cycle_end) begin
            case (mode)
                AGC_MODE_BASIC: begin
                    test = 1'b1;
                    filt = {6'h0, core_resp.result};
                end
                AGC_MODE_ACCUM, AGC_MODE_AVG, AGC_MODE_BURST,
                AGC_MODE_LPF: begin
                    acc_d = sum[15:0];
                    cnt_d = cnt_inc;
                    ovf   = (sum[17:16] != 2'h0);
                    filt  = (mode == AGC_MODE_LPF) ? sum[15:0]
                                                   : sum[15:0] >> shift;
                    test  = (mode == AGC_MODE_ACCUM)
                            || (cnt_inc >= rpt_q);
                    if (mode == AGC_MODE_AVG && test) begin
                        avg_clr_d = 1'b1;
                    end
                    if (mode == AGC_MODE_BURST) begin
                        restart_d = (cnt_inc < rpt_q);
                        burst_d   = (cnt_inc < rpt_q);
                    end
                end
                default: begin
                end
            endcase
        end
        if (aclr_wr) begin
            acc_d     = 16'h0;
            cnt_d     = 8'h0;
            avg_clr_d = 1'b0;
            st_d[`AGC_ST_OVF] = 1'b0;
        end
        if (clr_wr) begin
            st_d = st_d & ~pwdata[2:0];
        end
        // hardware set wins over software clear
        if (test && (filt > thr_q)) begin
            st_d[`AGC_ST_THR] = 1'b1;
        end
        if (ovf) begin
            st_d[`AGC_ST_OVF] = 1'b1;
        end
        if (conv_end) begin
            st_d[`AGC_ST_DONE] = 1'b1;
        end
        irq_d = |(st_d & ien_q);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_q     <= 10'h0;
            prev_q    <= 10'h0;
            acc_q     <= 16'h0;
            cnt_q     <= 8'h0;
            st_q      <= 3'h0;
            avg_clr_q <= 1'b0;
            burst_q   <= 1'b0;
            restart_q <= 1'b0;
            irq_q     <= 1'b0;
        end else begin
            cur_q     <= cur_d;
            prev_q    <= prev_d;
            acc_q     <= acc_d;
            cnt_q     <= cnt_d;
            st_q      <= st_d;
            avg_clr_q <= avg_clr_d;
            burst_q   <= burst_d;
            restart_q <= restart_d;
            irq_q     <= irq_d;
        end
    end

    assign pready  = pready_q;
    assign prdata  = prdata_q;
    assign pslverr = pslverr_q;
    assign irq     = irq_q;

    ////////////////////////////////////////////////////////////////////
    // checks
    sequence seq_pre_start;
        !busy && !burst_q && go_wr && (pre_q != 8'h00);
    endsequence
    a_guard_first_pre: assert property (@(posedge pclk)
        disable iff (!presetn)
        seq_pre_start |=> (core_ctrl.guard_out_a == ctrl_q[`AGC_CTRL_GPOL]
                           && core_ctrl.guard_out_b == ctrl_q[`AGC_CTRL_GPOL]
                           && core_ctrl.precharge))
        else $error("guards not at polarity in first precharge");
    a_skip_pre: assert property (@(posedge pclk) disable iff (!presetn)
        (!busy && !burst_q && go_wr && pre_q == 8'h00) |=>
        (core_ctrl.acquire && !core_ctrl.precharge))
        else $error("precharge not skipped");
    a_done_flag: assert property (@(posedge pclk) disable iff (!presetn)
        conv_end |=> st_q[`AGC_ST_DONE])
        else $error("done flag not set after conversion");
    a_cnt_saturate: assert property (@(posedge pclk) disable iff (!presetn)
        (cnt_q == 8'hff && !aclr_wr && !trig) |=> (cnt_q == 8'hff))
        else $error("sample counter wrapped");
    a_accum_add: assert property (@(posedge pclk) disable iff (!presetn)
        (cycle_end && mode == AGC_MODE_ACCUM && !dse && !aclr_wr) |=>
        (acc_q == 16'($past(acc_q) + {6'h0, $past(core_resp.result)})))
        else $error("accumulate sum wrong");
    a_basic_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (mode == AGC_MODE_BASIC && !aclr_wr && !trig) |=> $stable(acc_q))
        else $error("basic mode changed accumulator");
    a_burst_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (trig && mode == AGC_MODE_BURST && !cycle_end) |=>
        (acc_q == 16'h0 && cnt_q == 8'h0 && burst_q))
        else $error("burst trigger did not clear");
    a_prev_shift: assert property (@(posedge pclk) disable iff (!presetn)
        conv_end |=> (prev_q == $past(cur_q)
                      && cur_q == $past(core_resp.result)))
        else $error("result history wrong");
    a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 (irq_q == |($past(st_d) & $past(ien_q))))
        else $error("interrupt level wrong");
endmodule : agc_top
`default_nettype wire

/* design/agc_regs.svh */
`ifndef AGC_REGS_SVH
`define AGC_REGS_SVH
`define AGC_OFS_CTRL      8'h00
`define AGC_OFS_PRE_TIME  8'h04
`define AGC_OFS_ACQ_TIME  8'h08
`define AGC_OFS_CAP       8'h0c
`define AGC_OFS_REPEAT    8'h10
`define AGC_OFS_THRESH    8'h14
`define AGC_OFS_RESULT    8'h18
`define AGC_OFS_PREV      8'h1c
`define AGC_OFS_ACC       8'h20
`define AGC_OFS_COUNT     8'h24
`define AGC_OFS_STATUS    8'h28
`define AGC_OFS_INT_EN    8'h2c
`define AGC_OFS_INT_CLR   8'h30
`define AGC_CTRL_MODE_LSB 0
`define AGC_CTRL_DSE      3
`define AGC_CTRL_GPOL     4
`define AGC_CTRL_IPEN     5
`define AGC_CTRL_GO       8
`define AGC_CTRL_ACLR     9
`define AGC_CTRL_SHIFT_LSB 10
`define AGC_ST_DONE       0
`define AGC_ST_THR        1
`define AGC_ST_OVF        2
`define AGC_RST_CTRL      13'h0000
`define AGC_RST_BYTE      8'h00
`define AGC_RST_CAP       5'h00
`define AGC_RST_THRESH    16'hffff
`define AGC_CNT_MAX       8'hff
`endif

/* design/agc_pkg.sv */
package agc_pkg;
    typedef enum logic [2:0] {
        AGC_MODE_BASIC = 3'h0,
        AGC_MODE_ACCUM = 3'h1,
        AGC_MODE_AVG   = 3'h2,
        AGC_MODE_BURST = 3'h3,
        AGC_MODE_LPF   = 3'h4
    } agc_mode_t;

    typedef enum logic [3:0] {
        AGC_S_IDLE = 4'b0001,
        AGC_S_PRE  = 4'b0010,
        AGC_S_ACQ  = 4'b0100,
        AGC_S_CONV = 4'b1000
    } agc_state_t;

    typedef struct packed {
        logic       precharge;
        logic       acquire;
        logic       start;
        logic       guard_out_a;
        logic       guard_out_b;
        logic [4:0] extra_hold_cap_sel;
    } agc_core_ctrl_t;

    typedef struct packed {
        logic       done;
        logic [9:0] result;
    } agc_core_resp_t;
endpackage : agc_pkg

/* design/agc_seq.sv */
`timescale 1ns/1ps
`default_nettype none
module agc_seq
    import agc_pkg::*;
(
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire logic            start,
    input  wire logic [7:0]      precharge_time,
    input  wire logic [7:0]      acq_time,
    input  wire logic            double_sample_en,
    input  wire logic            guard_polarity,
    input  wire logic            second_precharge_invert_en,
    input  wire logic [4:0]      cap_sel,
    input  wire logic            core_done,
    output agc_pkg::agc_core_ctrl_t core_ctrl,
    output logic                 busy,
    output logic                 conv_end,
    output logic                 cycle_end
);
    import agc_pkg::*;

    agc_state_t     state_q, state_d;
    logic           second_q, second_d;
    logic [7:0]     tmr_q, tmr_d;
    agc_core_ctrl_t ctl_q, ctl_d;

    function automatic logic [7:0] acq_load(input logic [7:0] pre,
                                            input logic [7:0] acq);
        // zero acquisition without precharge: one cycle of acquisition
        acq_load = (pre == 8'h00 && acq == 8'h00) ? 8'h01 : acq;
    endfunction : acq_load

    always_comb begin
        state_d  = state_q;
        second_d = second_q;
        tmr_d    = tmr_q - 8'h01;
        ctl_d    = ctl_q;
        ctl_d.start = 1'b0;
        case (state_q)
            AGC_S_IDLE: begin
                if (start) begin
                    second_d = 1'b0;
                    if (precharge_time != 8'h00) begin
                        state_d = AGC_S_PRE;
                        tmr_d   = precharge_time;
                        ctl_d.guard_out_a = guard_polarity;
                        ctl_d.guard_out_b = guard_polarity;
                    end else begin
                        state_d = AGC_S_ACQ;
                        tmr_d   = acq_load(precharge_time, acq_time);
                        ctl_d.guard_out_a = ~guard_polarity;
                        ctl_d.guard_out_b = guard_polarity;
                    end
                end
            end
            AGC_S_PRE: begin
                if (tmr_q == 8'h01) begin
                    state_d = AGC_S_ACQ;
                    tmr_d   = acq_load(precharge_time, acq_time);
                    ctl_d.guard_out_a = ~ctl_q.guard_out_a;
                end
            end
            AGC_S_ACQ: begin
                if (tmr_q == 8'h01) begin
                    state_d     = AGC_S_CONV;
                    ctl_d.start = 1'b1;
                end
            end
            AGC_S_CONV: begin
                if (core_done) begin
                    if (double_sample_en && !second_q) begin
                        second_d = 1'b1;
                        if (precharge_time != 8'h00) begin
                            state_d = AGC_S_PRE;
                            tmr_d   = precharge_time;
                            ctl_d.guard_out_a = second_precharge_invert_en
                                ^ guard_polarity;
                            ctl_d.guard_out_b = second_precharge_invert_en
                                ^ guard_polarity;
                        end else begin
                            state_d = AGC_S_ACQ;
                            tmr_d   = acq_load(precharge_time, acq_time);
                            ctl_d.guard_out_a = ~ctl_q.guard_out_a;
                        end
                    end else begin
                        state_d = AGC_S_IDLE;
                    end
                end
            end
            default: begin
                state_d = AGC_S_IDLE;
            end
        endcase
        ctl_d.precharge = (state_d == AGC_S_PRE);
        ctl_d.acquire   = (state_d == AGC_S_ACQ);
        // extra capacitance off while converting
        ctl_d.extra_hold_cap_sel = (state_d == AGC_S_CONV) ? 5'h00
                                                           : cap_sel;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q  <= AGC_S_IDLE;
            second_q <= 1'b0;
            tmr_q    <= 8'h00;
            ctl_q    <= '0;
        end else begin
            state_q  <= state_d;
            second_q <= second_d;
            tmr_q    <= tmr_d;
            ctl_q    <= ctl_d;
        end
    end

    assign core_ctrl = ctl_q;
    assign busy      = (state_q != AGC_S_IDLE);
    assign conv_end  = (state_q == AGC_S_CONV) && core_done;
    assign cycle_end = conv_end && (!double_sample_en || second_q);

    a_cap_off_conv: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == AGC_S_CONV) |-> (ctl_q.extra_hold_cap_sel == 5'h00))
        else $error("extra cap connected during conversion");
    a_acq_flips_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == AGC_S_PRE && tmr_q == 8'h01) |=>
        (ctl_q.guard_out_a != $past(ctl_q.guard_out_a)
         && $stable(ctl_q.guard_out_b)))
        else $error("guard A not inverted at acquisition");
endmodule : agc_seq
`default_nettype wire

/* test/agc_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module agc_core_model
    import agc_pkg::*;
(
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire agc_pkg::agc_core_ctrl_t core_ctrl,
    input  wire logic [9:0]              value,
    output agc_pkg::agc_core_resp_t      core_resp
);
    logic [2:0] cnt_q;
    logic       done_w;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            cnt_q <= 3'h0;
        else if (core_ctrl.start)
            cnt_q <= 3'h4;
        else if (cnt_q != 3'h0)
            cnt_q <= cnt_q - 3'h1;
    end
    // result is garbage outside the done pulse
    assign done_w = (cnt_q == 3'h1);
    assign core_resp = {done_w, done_w ? value : ~value};
endmodule : agc_core_model
`default_nettype wire

/* test/agc_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "agc_regs.svh"
module agc_tb_top;
    import agc_pkg::*;
    logic           pclk = 1'b0;
    logic           presetn = 1'b0;
    logic           psel = 1'b0;
    logic           penable = 1'b0;
    logic           pwrite = 1'b0;
    logic [7:0]     paddr = 8'h00;
    logic [31:0]    pwdata = 32'h0;
    logic [9:0]     value = 10'h155;
    logic           ext_trig = 1'b0;
    logic           pready, pslverr, irq, last_err;
    logic [31:0]    prdata, rd;
    agc_core_resp_t core_resp;
    agc_core_ctrl_t core_ctrl;
    int             errors = 0;
    int             comparisons = 0;
    int             cycles = 0;
    always #12.5 pclk = ~pclk;
    agc_top i_agc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .ext_trigger(ext_trig), .core_resp(core_resp), .core_ctrl(core_ctrl),
        .irq(irq));
    agc_core_model i_agc_core_model (.pclk(pclk), .presetn(presetn),
        .core_ctrl(core_ctrl), .value(value), .core_resp(core_resp));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wait_bit(input int k);
        do begin
            @(negedge pclk);
        end while (core_ctrl[k] !== 1'b1);
    endtask : wait_bit
    task automatic wait_idle();
        do begin
            apb(1'b0, `AGC_OFS_CTRL, 32'h0);
        end while (rd[8] !== 1'b0);
    endtask : wait_idle
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask : rd_chk
    ////////////////////////////////////////////////////////////////////////
    task automatic t_basic();
        apb(1'b1, `AGC_OFS_PRE_TIME, 32'h2);
        apb(1'b1, `AGC_OFS_ACQ_TIME, 32'h1);
        apb(1'b1, `AGC_OFS_CAP, 32'h0a);
        apb(1'b1, `AGC_OFS_INT_EN, 32'h1);
        apb(1'b1, `AGC_OFS_CTRL, 32'h110);
        wait_bit(9);
        chk(core_ctrl[6:0], 32'h6a);
        wait_bit(8);
        chk(core_ctrl[6:5], 32'h1);
        wait_bit(7);
        chk(core_ctrl[4:0], 32'h0);
        wait_idle();
        rd_chk(`AGC_OFS_STATUS, 32'h1);
        chk(irq, 1'b1);
        rd_chk(`AGC_OFS_RESULT, 32'h155);
        apb(1'b1, `AGC_OFS_INT_CLR, 32'h7);
        @(posedge pclk);
        chk(irq, 1'b0);
        apb(1'b0, 8'h34, 32'h0);
        chk(last_err, 1'b1);
    endtask : t_basic
    task automatic t_double();
        apb(1'b1, `AGC_OFS_CTRL, 32'h128);
        wait_bit(9);
        chk(core_ctrl[6:5], 32'h0);
        wait_bit(7);
        wait_bit(9);
        value <= 10'h2aa;
        chk(core_ctrl[6:5], 32'h3);
        wait_bit(8);
        chk(core_ctrl[6:5], 32'h1);
        wait_idle();
        rd_chk(`AGC_OFS_PREV, 32'h155);
        rd_chk(`AGC_OFS_RESULT, 32'h2aa);
    endtask : t_double
    task automatic t_accum();
        apb(1'b1, `AGC_OFS_CTRL, 32'h201);
        repeat (2) begin
            apb(1'b1, `AGC_OFS_CTRL, 32'h101);
            wait_idle();
        end
        rd_chk(`AGC_OFS_ACC, 32'h554);
        rd_chk(`AGC_OFS_COUNT, 32'h2);
    endtask : t_accum
    task automatic t_burst();
        apb(1'b1, `AGC_OFS_REPEAT, 32'h3);
        apb(1'b1, `AGC_OFS_THRESH, 32'h0);
        apb(1'b1, `AGC_OFS_INT_CLR, 32'h7);
        apb(1'b1, `AGC_OFS_CTRL, 32'h203);
        apb(1'b1, `AGC_OFS_CTRL, 32'h103);
        wait_idle();
        rd_chk(`AGC_OFS_COUNT, 32'h3);
        rd_chk(`AGC_OFS_ACC, 32'h7fe);
        rd_chk(`AGC_OFS_STATUS, 32'h3);
    endtask : t_burst
    task automatic pulse_ext();
        ext_trig <= 1'b1;
        repeat (5) @(posedge pclk);
        ext_trig <= 1'b0;
        wait_idle();
    endtask : pulse_ext
    task automatic t_diff();
        apb(1'b1, `AGC_OFS_CTRL, 32'h209);
        apb(1'b1, `AGC_OFS_INT_CLR, 32'h7);
        apb(1'b1, `AGC_OFS_CTRL, 32'h109);
        wait_bit(7);
        wait_bit(9);
        value <= 10'h155;
        wait_idle();
        rd_chk(`AGC_OFS_ACC, 32'hfeab);
        rd_chk(`AGC_OFS_STATUS, 32'h7);
    endtask : t_diff
    task automatic t_avg();
        apb(1'b1, `AGC_OFS_CTRL, 32'h202);
        apb(1'b1, `AGC_OFS_REPEAT, 32'h2);
        apb(1'b1, `AGC_OFS_INT_CLR, 32'h7);
        pulse_ext();
        rd_chk(`AGC_OFS_STATUS, 32'h1);
        pulse_ext();
        rd_chk(`AGC_OFS_STATUS, 32'h3);
        apb(1'b1, `AGC_OFS_CTRL, 32'h102);
        wait_idle();
        rd_chk(`AGC_OFS_ACC, 32'h155);
        rd_chk(`AGC_OFS_COUNT, 32'h1);
    endtask : t_avg
    task automatic t_lpf();
        apb(1'b1, `AGC_OFS_CTRL, 32'h604);
        apb(1'b1, `AGC_OFS_INT_CLR, 32'h7);
        apb(1'b1, `AGC_OFS_CTRL, 32'h504);
        wait_idle();
        rd_chk(`AGC_OFS_STATUS, 32'h1);
        apb(1'b1, `AGC_OFS_CTRL, 32'h504);
        wait_idle();
        rd_chk(`AGC_OFS_ACC, 32'h200);
        rd_chk(`AGC_OFS_STATUS, 32'h3);
    endtask : t_lpf
    task automatic t_sat();
        apb(1'b1, `AGC_OFS_REPEAT, 32'hff);
        apb(1'b1, `AGC_OFS_CTRL, 32'h203);
        apb(1'b1, `AGC_OFS_CTRL, 32'h103);
        wait_idle();
        rd_chk(`AGC_OFS_COUNT, 32'hff);
        apb(1'b1, `AGC_OFS_CTRL, 32'h101);
        wait_idle();
        rd_chk(`AGC_OFS_COUNT, 32'hff);
    endtask : t_sat
    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        if (errors == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_basic();
        t_double();
        t_accum();
        t_burst();
        t_diff();
        t_avg();
        t_lpf();
        t_sat();
        give_verdict();
    end
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            give_verdict();
        end
    end
endmodule : agc_tb_top
`default_nettype wire
